// File: core/acp_pkg.sv
// constants, state type and helpers for the converter control and parallel port
package acp_pkg;
	localparam int CLK_PERIOD_NS    = 4;
	localparam int CONV_RISE_EDGES  = 13;
	localparam int T_DATA_LEAD_NS   = 10;
	localparam int DATA_LEAD_CYCLES = (T_DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESULT_W         = 12;
	localparam int CHAN_W           = 3;
	localparam int LANE_W           = 8;
	localparam int UPPER_W          = 3;
	localparam int CNT_W            = 4;
	localparam int HI_NIBBLE_LSB    = 8;
	localparam int CHAN_LANE_LSB    = 4;
	localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
	localparam logic [CHAN_W-1:0]   CHAN_RST   = 3'h0;
	localparam logic [LANE_W-1:0]   LANE_RST   = 8'h00;
	localparam logic [CNT_W-1:0]    CNT_RST    = 4'h0;
	localparam logic [CNT_W-1:0]    CNT_LAST   = 4'(CONV_RISE_EDGES - 1);
	localparam logic [CNT_W-1:0]    LEAD_LAST  = 4'(DATA_LEAD_CYCLES - 1);

	// gray order along idle, wait, count, lead
	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_WAIT_FALL = 2'b01,
		ST_COUNT     = 2'b11,
		ST_LEAD      = 2'b10
	} acp_state_type;

	function automatic logic fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction

	function automatic logic rose(input logic prev, input logic cur);
		return ~prev & cur;
	endfunction
endpackage

// File: core/acp_result_if.sv
// carrier between the conversion core and the host port
`timescale 1ns/1ns
interface acp_result_if;
	import acp_pkg::*;
	logic [RESULT_W-1:0] result;
	logic [CHAN_W-1:0]   channel;
	logic [RESULT_W-1:0] wr_word;
	logic                wr_stb;
	modport core (output result, output channel, input wr_word, input wr_stb);
	modport port (input result, input channel, output wr_word, output wr_stb);
endinterface

// File: core/acp_host_port.sv
// three-state parallel host port: reads of the result, writes into the registers
`timescale 1ns/1ns
module acp_host_port
	import acp_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                cs_n,
	input  wire logic                rd_n,
	input  wire logic                wr_n,
	input  wire logic                word_mode,
	input  wire logic [LANE_W-1:0]   low_byte_lanes_in,
	output logic      [LANE_W-1:0]   low_byte_lanes_out,
	output logic                     low_byte_lanes_oe_n,
	input  wire logic                bit8_upper_byte_select_in,
	output logic                     bit8_upper_byte_select_out,
	output logic                     bit8_upper_byte_select_oe_n,
	input  wire logic [UPPER_W-1:0]  upper_word_lanes_in,
	output logic      [UPPER_W-1:0]  upper_word_lanes_out,
	output logic                     upper_word_lanes_oe_n,
	acp_result_if.port               rif
);
	logic [LANE_W-1:0]   low_out_reg, low_out_next;
	logic                low_oe_reg, low_oe_next;
	logic                b8_out_reg, b8_out_next;
	logic                b8_oe_reg, b8_oe_next;
	logic [UPPER_W-1:0]  up_out_reg, up_out_next;
	logic                up_oe_reg, up_oe_next;
	logic                wr_act_reg, wr_act_next;
	logic [RESULT_W-1:0] cap_reg, cap_next;
	logic                cap_word_reg, cap_word_next;
	logic                cap_hi_reg, cap_hi_next;
	logic [LANE_W-1:0]   pend_low_reg, pend_low_next;
	logic [RESULT_W-1:0] word_reg, word_next;
	logic                stb_reg, stb_next;
	logic                rd_act;
	logic                wr_act;

	assign rd_act = ~cs_n & ~rd_n;
	assign wr_act = ~cs_n & ~wr_n;

	// read path: lanes follow the bus mode; the shared pin is only driven in word mode
	always_comb begin
		low_out_next = low_out_reg;
		b8_out_next  = b8_out_reg;
		up_out_next  = up_out_reg;
		low_oe_next  = 1'b1;
		b8_oe_next   = 1'b1;
		up_oe_next   = 1'b1;
		if (rd_act) begin // R15 R1
			low_oe_next = 1'b0;
			if (word_mode) begin // R6 R2
				low_out_next = rif.result[LANE_W-1:0];
				b8_out_next  = rif.result[LANE_W];
				up_out_next  = rif.result[RESULT_W-1:LANE_W+1];
				b8_oe_next   = 1'b0;
				up_oe_next   = 1'b0;
			end else if (bit8_upper_byte_select_in) begin // R3 R4
				low_out_next = {1'b0, rif.channel, rif.result[RESULT_W-1:HI_NIBBLE_LSB]};
			end else begin // R3
				low_out_next = rif.result[LANE_W-1:0];
			end
		end
	end

	// write path: data is captured while the strobe is low and committed as it rises
	always_comb begin
		wr_act_next   = wr_act;
		cap_next      = cap_reg;
		cap_word_next = cap_word_reg;
		cap_hi_next   = cap_hi_reg;
		pend_low_next = pend_low_reg;
		word_next     = word_reg;
		stb_next      = 1'b0;
		if (wr_act) begin // R14
			cap_word_next = word_mode;
			cap_hi_next   = bit8_upper_byte_select_in;
			cap_next      = {upper_word_lanes_in, bit8_upper_byte_select_in, low_byte_lanes_in};
		end
		// lanes 4..7 of a high byte are the host's to zero, so they are simply dropped
		if (wr_act_reg && !wr_act) begin // R14 R5
			if (cap_word_reg) begin
				word_next = cap_reg;
				stb_next  = 1'b1;
			end else if (cap_hi_reg) begin
				word_next = {cap_reg[3:0], pend_low_reg};
				stb_next  = 1'b1;
			end else begin
				pend_low_next = cap_reg[LANE_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_out_reg  <= LANE_RST;
			low_oe_reg   <= 1'b1;
			b8_out_reg   <= 1'b0;
			b8_oe_reg    <= 1'b1;
			up_out_reg   <= 3'h0;
			up_oe_reg    <= 1'b1;
			wr_act_reg   <= 1'b0;
			cap_reg      <= RESULT_RST;
			cap_word_reg <= 1'b0;
			cap_hi_reg   <= 1'b0;
			pend_low_reg <= LANE_RST;
			word_reg     <= RESULT_RST;
			stb_reg      <= 1'b0;
		end else begin
			low_out_reg  <= low_out_next;
			low_oe_reg   <= low_oe_next;
			b8_out_reg   <= b8_out_next;
			b8_oe_reg    <= b8_oe_next;
			up_out_reg   <= up_out_next;
			up_oe_reg    <= up_oe_next;
			wr_act_reg   <= wr_act_next;
			cap_reg      <= cap_next;
			cap_word_reg <= cap_word_next;
			cap_hi_reg   <= cap_hi_next;
			pend_low_reg <= pend_low_next;
			word_reg     <= word_next;
			stb_reg      <= stb_next;
		end
	end

	assign low_byte_lanes_out          = low_out_reg;
	assign low_byte_lanes_oe_n         = low_oe_reg;
	assign bit8_upper_byte_select_out  = b8_out_reg;
	assign bit8_upper_byte_select_oe_n = b8_oe_reg;
	assign upper_word_lanes_out        = up_out_reg;
	assign upper_word_lanes_oe_n       = up_oe_reg;
	assign rif.wr_word                 = word_reg;
	assign rif.wr_stb                  = stb_reg;

	property p_read_drive;
		@(posedge clk) disable iff (sys_rst) rd_act |=> !low_byte_lanes_oe_n;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven"); // R15

	property p_byte_mode_pin;
		@(posedge clk) disable iff (sys_rst) !$past(word_mode) |-> bit8_upper_byte_select_oe_n;
	endproperty
	a_byte_mode_pin: assert property (p_byte_mode_pin) else $error("select pin driven"); // R2

	property p_high_byte;
		@(posedge clk) disable iff (sys_rst)
		rd_act && !word_mode && bit8_upper_byte_select_in |=>
		low_byte_lanes_out == {1'b0, $past(rif.channel), $past(rif.result[11:8])};
	endproperty
	a_high_byte: assert property (p_high_byte) else $error("high byte wrong"); // R4

	property p_word_read;
		@(posedge clk) disable iff (sys_rst) rd_act && word_mode |=>
		{upper_word_lanes_out, bit8_upper_byte_select_out, low_byte_lanes_out}
		== $past(rif.result) && !upper_word_lanes_oe_n;
	endproperty
	a_word_read: assert property (p_word_read) else $error("word read wrong"); // R6

	property p_word_write;
		@(posedge clk) disable iff (sys_rst) wr_act && word_mode ##1 !wr_act |=>
		stb_reg && word_reg == $past(cap_reg);
	endproperty
	a_word_write: assert property (p_word_write) else $error("word write lost"); // R14
endmodule // acp_host_port

// File: core/acp_conv_ctrl.sv
// conversion control: start edge, master-clock count, busy, result register
`timescale 1ns/1ns
import acp_pkg::*;
// Functional notes
// R1: data lanes carry result and register writes
// R2: word mode pin is bit 8, else select
// R3: byte mode splits low byte and nibble
// R4: high byte read carries channel identifier
// R5: host zeroes lanes four to seven writing
// R6: word mode moves twelve bits at once
// R7: busy rises after start, holds during conversion
// R8: busy falls once result is held
// R9: tracking resumes on thirteenth rising edge
// R10: conversion spans thirteen master clock cycles
// R11: works with continuous or burst clock
// R12: start falling edge holds and converts
// R13: start rising edge wakes after power-down
// R14: write strobe with select latches data
// R15: read strobe with select drives result
// R16: host keeps quiet time before start
// R17: result and channel held until next
// R18: host waits for busy low to start
module acp_conv_ctrl
	import acp_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                conversion_start_n,
	input  wire logic                master_conversion_clock,
	input  wire logic                power_down_req,
	input  wire logic [RESULT_W-1:0] sar_result,
	input  wire logic [CHAN_W-1:0]   sar_channel,
	input  wire logic                cs_n,
	input  wire logic                rd_n,
	input  wire logic                wr_n,
	input  wire logic                word_mode,
	input  wire logic [LANE_W-1:0]   low_byte_lanes_in,
	output logic      [LANE_W-1:0]   low_byte_lanes_out,
	output logic                     low_byte_lanes_oe_n,
	input  wire logic                bit8_upper_byte_select_in,
	output logic                     bit8_upper_byte_select_out,
	output logic                     bit8_upper_byte_select_oe_n,
	input  wire logic [UPPER_W-1:0]  upper_word_lanes_in,
	output logic      [UPPER_W-1:0]  upper_word_lanes_out,
	output logic                     upper_word_lanes_oe_n,
	output logic                     busy,
	output logic                     track_mode,
	output logic                     awake,
	output logic      [RESULT_W-1:0] reg_write_word,
	output logic                     reg_write_strobe
);
	acp_state_type       state_reg, state_next;
	logic [CNT_W-1:0]    cnt_reg, cnt_next;
	logic                busy_reg, busy_next;
	logic                track_reg, track_next;
	logic                awake_reg, awake_next;
	logic                start_prev_reg;
	logic                mclk_prev_reg;
	logic [RESULT_W-1:0] result_reg, result_next;
	logic [CHAN_W-1:0]   chan_reg, chan_next;
	logic [RESULT_W-1:0] write_word_reg;
	logic                write_stb_reg;
	logic                conv_fall;
	logic                conv_rise;
	logic                mclk_fall;
	logic                mclk_rise;
	acp_result_if        rif ();

	// pins are synchronous to clk, so one stored sample is enough for edges
	assign conv_fall = fell(start_prev_reg, conversion_start_n);
	assign conv_rise = rose(start_prev_reg, conversion_start_n);
	assign mclk_fall = fell(mclk_prev_reg, master_conversion_clock);
	assign mclk_rise = rose(mclk_prev_reg, master_conversion_clock);

	// wake on a rising start edge; it wins over a power-down request in the same cycle
	always_comb begin
		awake_next = awake_reg;
		if (conv_rise) begin // R13
			awake_next = 1'b1;
		end else if (power_down_req) begin
			awake_next = 1'b0;
		end
	end

	// conversion sequence; progress waits on clock edges only, so a burst clock
	// that stops simply stalls the count rather than timing it out
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		busy_next   = busy_reg;
		track_next  = track_reg;
		result_next = result_reg;
		chan_next   = chan_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (conv_fall && awake_reg) begin // R12 R7
					state_next = ST_WAIT_FALL;
					busy_next  = 1'b1;
					track_next = 1'b0;
					cnt_next   = CNT_RST;
				end
			end
			ST_WAIT_FALL: begin
				if (mclk_fall) begin // R10 R11
					state_next = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (mclk_rise) begin // R10
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == CNT_LAST) begin // R9 R17
						state_next  = ST_LEAD;
						track_next  = 1'b1;
						result_next = sar_result;
						chan_next   = sar_channel;
						cnt_next    = CNT_RST;
					end
				end
			end
			ST_LEAD: begin
				// data must stand before busy drops, so busy lags the latch
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == LEAD_LAST) begin // R8
					state_next = ST_IDLE;
					busy_next  = 1'b0;
					cnt_next   = CNT_RST;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= CNT_RST;
			busy_reg       <= 1'b0;
			track_reg      <= 1'b1;
			awake_reg      <= 1'b1;
			start_prev_reg <= 1'b1;
			mclk_prev_reg  <= master_conversion_clock; // follow the pin: no false edge on release
			result_reg     <= RESULT_RST;
			chan_reg       <= CHAN_RST;
			write_word_reg <= RESULT_RST;
			write_stb_reg  <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			busy_reg       <= busy_next;
			track_reg      <= track_next;
			awake_reg      <= awake_next;
			start_prev_reg <= conversion_start_n;
			mclk_prev_reg  <= master_conversion_clock;
			result_reg     <= result_next;
			chan_reg       <= chan_next;
			write_word_reg <= rif.wr_word;
			write_stb_reg  <= rif.wr_stb;
		end
	end

	assign rif.result       = result_reg;
	assign rif.channel      = chan_reg;
	assign busy             = busy_reg;
	assign track_mode       = track_reg;
	assign awake            = awake_reg;
	assign reg_write_word   = write_word_reg;
	assign reg_write_strobe = write_stb_reg;

	acp_host_port acp_host_port_inst (
		.clk                         (clk),
		.sys_rst                     (sys_rst),
		.cs_n                        (cs_n),
		.rd_n                        (rd_n),
		.wr_n                        (wr_n),
		.word_mode                   (word_mode),
		.low_byte_lanes_in           (low_byte_lanes_in),
		.low_byte_lanes_out          (low_byte_lanes_out),
		.low_byte_lanes_oe_n         (low_byte_lanes_oe_n),
		.bit8_upper_byte_select_in   (bit8_upper_byte_select_in),
		.bit8_upper_byte_select_out  (bit8_upper_byte_select_out),
		.bit8_upper_byte_select_oe_n (bit8_upper_byte_select_oe_n),
		.upper_word_lanes_in         (upper_word_lanes_in),
		.upper_word_lanes_out        (upper_word_lanes_out),
		.upper_word_lanes_oe_n       (upper_word_lanes_oe_n),
		.rif                         (rif.port)
	);

	// helper: master-clock rising edges seen in the counting state
	logic [CNT_W-1:0] rise_seen_reg, rise_seen_next;
	always_comb begin
		rise_seen_next = rise_seen_reg;
		if (state_reg != ST_COUNT) begin
			rise_seen_next = CNT_RST;
		end else if (mclk_rise) begin
			rise_seen_next = rise_seen_reg + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rise_seen_reg <= CNT_RST;
		end else begin
			rise_seen_reg <= rise_seen_next;
		end
	end

	property p_busy_rise;
		@(posedge clk) disable iff (sys_rst)
		conv_fall && awake_reg && state_reg == ST_IDLE |=> busy && !track_mode;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy missed start"); // R7

	property p_busy_during;
		@(posedge clk) disable iff (sys_rst)
		state_reg == ST_WAIT_FALL || state_reg == ST_COUNT |-> busy && !track_mode;
	endproperty
	a_busy_during: assert property (p_busy_during) else $error("busy dropped early"); // R12

	property p_busy_fall;
		@(posedge clk) disable iff (sys_rst)
		$rose(track_mode) |-> busy[*3] ##1 !busy && $stable(result_reg);
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("busy fall timing"); // R8

	property p_thirteen;
		@(posedge clk) disable iff (sys_rst)
		$rose(track_mode) |-> $past(rise_seen_reg) == 4'hC && $past(mclk_rise);
	endproperty
	a_thirteen: assert property (p_thirteen) else $error("not thirteenth edge"); // R9

	property p_result_hold;
		@(posedge clk) disable iff (sys_rst)
		!$rose(track_mode) |-> $stable(result_reg) && $stable(chan_reg);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed"); // R17

	property p_asleep;
		@(posedge clk) disable iff (sys_rst)
		!awake_reg && conv_fall && state_reg == ST_IDLE |=> !busy;
	endproperty
	a_asleep: assert property (p_asleep) else $error("start while asleep"); // R13

	property p_wake;
		@(posedge clk) disable iff (sys_rst) conv_rise |=> awake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on rise"); // R13
endmodule // acp_conv_ctrl

// File: verification/acp_host_model.sv
// host side model: bus cycles, start pin, burst master clock and lane wire levels
`timescale 1ns/1ns
module acp_host_model
	import acp_pkg::*;
(
	input  wire logic                clk,
	input  wire logic [LANE_W-1:0]   lo_out,
	input  wire logic                lo_oe_n,
	input  wire logic                b8_out,
	input  wire logic                b8_oe_n,
	input  wire logic [UPPER_W-1:0]  up_out,
	input  wire logic                up_oe_n,
	output logic                     cs_n,
	output logic                     rd_n,
	output logic                     wr_n,
	output logic                     word_mode,
	output logic                     start_n,
	output logic                     mclk,
	output logic      [LANE_W-1:0]   lo_in,
	output logic                     b8_in,
	output logic      [UPPER_W-1:0]  up_in
);
	logic [LANE_W-1:0]   lo_drv  = 8'h00;
	logic                b8_drv  = 1'b0;
	logic [UPPER_W-1:0]  up_drv  = 3'h0;
	logic [RESULT_W-1:0] wdat    = 12'h000;
	logic                drv_on  = 1'b0;
	logic                wm_req  = 1'b1;
	logic                sel_req = 1'b0;
	logic                mclk_en = 1'b0;
	logic [1:0]          mcnt    = 2'h0;

	// idle levels; the master clock rests high so the first change is a fall
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		word_mode = 1'b1;
		start_n = 1'b1;
		mclk = 1'b1;
	end

	// wire level: whoever enables wins, a released lane flips so stale data never matches
	assign lo_in = lo_oe_n ? lo_drv : lo_out;
	assign b8_in = b8_oe_n ? b8_drv : b8_out;
	assign up_in = up_oe_n ? up_drv : up_out;

	// requests are posted at a rising edge and applied here, off the sampling edge
	always @(negedge clk) begin
		word_mode <= wm_req;
		lo_drv <= drv_on ? wdat[7:0] : ~lo_drv;
		up_drv <= drv_on ? wdat[11:9] : ~up_drv;
		b8_drv <= !wm_req ? sel_req : (drv_on ? wdat[8] : ~b8_drv);
		if (mclk_en || !mclk) begin
			mcnt <= mcnt + 2'h1;
			if (mcnt == 2'h3)
				mclk <= ~mclk;
		end
	end

	task automatic set_start(input logic v);
		if (!v)
			repeat (8) @(negedge clk);
		start_n = v;
	endtask

	task automatic read_bus(input logic wm, input logic sel, output logic [15:0] q);
		@(posedge clk);
		wm_req = wm;
		sel_req = sel;
		@(negedge clk);
		cs_n = 1'b0;
		rd_n = 1'b0;
		repeat (2) @(negedge clk);
		q = {1'b0, lo_oe_n, b8_oe_n, up_oe_n, up_in, b8_in, lo_in};
		cs_n = 1'b1;
		rd_n = 1'b1;
	endtask

	// data stays on the lanes until wr has been seen high
	task automatic write_bus(input logic wm, input logic sel, input logic [RESULT_W-1:0] d);
		@(posedge clk);
		wm_req = wm;
		sel_req = sel;
		wdat = d;
		drv_on = 1'b1;
		@(negedge clk);
		cs_n = 1'b0;
		wr_n = 1'b0;
		repeat (2) @(negedge clk);
		cs_n = 1'b1;
		wr_n = 1'b1;
		@(posedge clk);
		drv_on = 1'b0;
	endtask
endmodule // acp_host_model

// File: verification/adc_conversion_parallel_port_tb_top.sv
// testbench top: conversions, port reads, register writes, power-down wake
`timescale 1ns/1ns
module adc_conversion_parallel_port_tb_top
	import acp_pkg::*;
;
	logic                clk;
	logic                sys_rst;
	logic                power_down_req;
	logic [RESULT_W-1:0] sar_result;
	logic [CHAN_W-1:0]   sar_channel;
	logic                cs_n, rd_n, wr_n, word_mode, start_n, mclk, mclk_q;
	logic [LANE_W-1:0]   lo_in, lo_out;
	logic                b8_in, b8_out, lo_oe_n, b8_oe_n, up_oe_n;
	logic [UPPER_W-1:0]  up_in, up_out;
	logic                busy, track_mode, awake, reg_write_strobe;
	logic [RESULT_W-1:0] reg_write_word;
	int                  err_total  = 0;
	int                  n_compared = 0;
	int                  rises      = 0;

	acp_conv_ctrl acp_conv_ctrl_inst (
		.clk                         (clk),
		.sys_rst                     (sys_rst),
		.conversion_start_n          (start_n),
		.master_conversion_clock     (mclk),
		.power_down_req              (power_down_req),
		.sar_result                  (sar_result),
		.sar_channel                 (sar_channel),
		.cs_n                        (cs_n),
		.rd_n                        (rd_n),
		.wr_n                        (wr_n),
		.word_mode                   (word_mode),
		.low_byte_lanes_in           (lo_in),
		.low_byte_lanes_out          (lo_out),
		.low_byte_lanes_oe_n         (lo_oe_n),
		.bit8_upper_byte_select_in   (b8_in),
		.bit8_upper_byte_select_out  (b8_out),
		.bit8_upper_byte_select_oe_n (b8_oe_n),
		.upper_word_lanes_in         (up_in),
		.upper_word_lanes_out        (up_out),
		.upper_word_lanes_oe_n       (up_oe_n),
		.busy                        (busy),
		.track_mode                  (track_mode),
		.awake                       (awake),
		.reg_write_word              (reg_write_word),
		.reg_write_strobe            (reg_write_strobe)
	);

	acp_host_model acp_host_model_inst (
		.clk       (clk),
		.lo_out    (lo_out),
		.lo_oe_n   (lo_oe_n),
		.b8_out    (b8_out),
		.b8_oe_n   (b8_oe_n),
		.up_out    (up_out),
		.up_oe_n   (up_oe_n),
		.cs_n      (cs_n),
		.rd_n      (rd_n),
		.wr_n      (wr_n),
		.word_mode (word_mode),
		.start_n   (start_n),
		.mclk      (mclk),
		.lo_in     (lo_in),
		.b8_in     (b8_in),
		.up_in     (up_in)
	);

	// 250 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// master clock rises seen while a conversion holds the sample
	initial mclk_q = 1'b1;
	always @(posedge clk) begin
		mclk_q <= mclk;
		if (busy === 1'b1 && track_mode === 1'b0 && mclk && !mclk_q)
			rises <= rises + 1;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("compared %0d, mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// burst mode parks the master clock mid-conversion; the count must just stall
	task automatic t_conv(input logic burst, input logic [RESULT_W-1:0] res,
		input logic [CHAN_W-1:0] ch);
		int k;
		int r0;
		sar_result = res;
		sar_channel = ch;
		acp_host_model_inst.set_start(1'b0);
		r0 = rises;
		check(busy, 1'b0);
		@(negedge clk);
		check({busy, track_mode}, 2'b10);
		acp_host_model_inst.mclk_en <= 1'b1;
		acp_host_model_inst.set_start(1'b1);
		k = 0;
		while (track_mode !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
			if (burst && k == 20)
				acp_host_model_inst.mclk_en <= 1'b0;
			if (burst && k == 50)
				acp_host_model_inst.mclk_en <= 1'b1;
		end
		check(16'(rises - r0), 16'(CONV_RISE_EDGES));
		repeat (DATA_LEAD_CYCLES - 1) @(negedge clk);
		check(busy, 1'b1);
		@(negedge clk);
		check(busy, 1'b0);
		acp_host_model_inst.mclk_en <= 1'b0;
		$display("conversion test ended, burst %0d", burst);
	endtask

	task automatic t_read(input logic [RESULT_W-1:0] res, input logic [CHAN_W-1:0] ch);
		logic [15:0] q;
		acp_host_model_inst.read_bus(1'b1, 1'b0, q);
		check(q, {4'h0, res});
		acp_host_model_inst.read_bus(1'b0, 1'b0, q);
		check({q[14:12], q[7:0]}, {3'b011, res[7:0]});
		acp_host_model_inst.read_bus(1'b0, 1'b1, q);
		check({q[14:12], q[7:0]}, {3'b011, 1'b0, ch, res[11:8]});
		repeat (2) @(negedge clk);
		check({lo_oe_n, b8_oe_n, up_oe_n}, 3'b111);
		$display("read test ended");
	endtask

	task automatic wait_strobe(input logic hit, input logic [RESULT_W-1:0] exp);
		int k;
		k = 0;
		@(negedge clk);
		while (reg_write_strobe !== 1'b1 && k < 6) begin
			@(negedge clk);
			k++;
		end
		check(reg_write_strobe, hit);
		if (hit) begin
			check(16'(k), 16'h0001);
			check(reg_write_word, exp);
		end
		@(negedge clk);
		check(reg_write_strobe, 1'b0);
	endtask

	task automatic t_write();
		acp_host_model_inst.write_bus(1'b1, 1'b0, 12'hA5C);
		wait_strobe(1'b1, 12'hA5C);
		acp_host_model_inst.write_bus(1'b0, 1'b0, 12'h03C);
		wait_strobe(1'b0, 12'h000);
		acp_host_model_inst.write_bus(1'b0, 1'b1, 12'h009);
		wait_strobe(1'b1, 12'h93C);
		$display("write test ended");
	endtask

	// a fall while asleep is ignored, only the rise wakes the device
	task automatic t_wake();
		power_down_req = 1'b1;
		@(negedge clk);
		power_down_req = 1'b0;
		@(negedge clk);
		check(awake, 1'b0);
		acp_host_model_inst.set_start(1'b0);
		repeat (3) @(negedge clk);
		check(busy, 1'b0);
		acp_host_model_inst.set_start(1'b1);
		repeat (2) @(negedge clk);
		check({awake, busy}, 2'b10);
		$display("wake test ended");
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		power_down_req = 1'b0;
		sar_result = 12'h000;
		sar_channel = 3'h0;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		check({busy, track_mode, awake, lo_oe_n, b8_oe_n, up_oe_n, reg_write_strobe}, 7'h3E);
		t_conv(1'b0, 12'h5A3, 3'h5);
		t_read(12'h5A3, 3'h5);
		sar_result = 12'h0F0;
		sar_channel = 3'h2;
		t_read(12'h5A3, 3'h5);
		t_conv(1'b1, 12'hFFF, 3'h7);
		t_read(12'hFFF, 3'h7);
		t_write();
		t_wake();
		test_done();
	end

	// a hang is cut off well past the expected few hundred cycles
	initial begin
		#40000;
		err_total++;
		$display("watchdog expired at %0t", $time);
		test_done();
	end
endmodule // adc_conversion_parallel_port_tb_top
